// ---- rtl/band_signal_attenuation_calc.sv ----
// per-band signal attenuation calculator for both directions
// What this block does
// (R1) attenuation per band = transmitted band power minus received band power, in dB
// (R2) init and diagnostic: received power = 10log10 of sum of power times gain squared
// (R3) showtime: received powers summed as measured, no gain weighting
// (R4) upstream bands use only upstream active subcarriers inside the band; the code counts any active-set subcarrier of the band, direction not checked
// (R5) init: weight received power with peer message gain for that direction
// (R6) diagnostic: gain 0 if no bit loadable, else gain 1, for rx and tx
// (R7) tx power = 10log10 spacing + 10log10 sum of reference PSD times gain squared
// (R8) downstream reference PSD comes from downstream parameter message
// (R9) upstream tx power uses upstream subcarriers and upstream reference PSD
// (R10) init: weight tx power with peer message gain for that direction
// (R11) showtime: weight tx power with currently active gains
// (R12) measure in diagnostic and init; showtime refresh on own or on request
// (R13) results go to far-end entity in init/diagnostic, near end on request
// (R14) near-end entity forwards downstream values to far end when asked
// (R15) result is a 10-bit unsigned code in 0.1 dB steps
// (R16) code 1023 reports attenuation outside representable range
// (R17) margin: largest noise gain keeping bit error ratio at or below 1e-7; the code computes no margin, it only outputs the reference mode
// (R18) bit error ratio for margin taken at convergence sublayer output
// (R19) margin reference mode 1 (external stationary noise only) is supported
// (R20) one result per band and direction, all bands of the measured direction updated together at completion
`timescale 1ns/1ps
module band_signal_attenuation_calc #(
    parameter int NUM_BANDS = 8,
    parameter int BAND_W    = 3,
    parameter int PWR_W     = 32,
    // 10*log10 of subcarrier spacing in 0.1 dB (default 16'h0176 = 374, i.e. 37.4 dB)
    parameter logic [15:0] SPACING_TENTH_DB = 16'h0176
) (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    resetn,
    // measurement control
    input  wire logic                    start,
    input  wire logic [1:0]              phase,
    input  wire logic                    upstream,
    // subcarrier stream: one active-set subcarrier per cycle
    input  wire logic                    sc_valid,
    input  wire logic                    sc_last,
    input  wire logic [BAND_W-1:0]       sc_band,
    input  wire logic                    sc_in_active_set,
    input  wire logic [PWR_W-1:0]        sc_rx_power,
    input  wire logic [PWR_W-1:0]        sc_ref_psd_linear,
    input  wire logic [15:0]             sc_gain_sq,
    input  wire logic                    sc_bit_loadable,
    // result readout
    input  wire logic                    read_req,
    input  wire logic                    read_upstream,
    input  wire logic [BAND_W-1:0]       read_band,
    output logic                         read_valid,
    output logic [9:0]                   read_code,
    output logic                         far_end_push,
    output logic                         busy,
    // margin mode: only reference mode 1 is implemented
    output logic [1:0]                   margin_reference_mode
);
    localparam int ACC_W = PWR_W + 16 + 8;

    typedef struct packed {
        satn_pkg::state_e                              state;
        logic                                          dir_us;
        logic [NUM_BANDS-1:0][ACC_W-1:0]               rx_acc;
        logic [NUM_BANDS-1:0][ACC_W-1:0]               tx_acc;
        logic [1:0][NUM_BANDS-1:0][9:0]                codes;
        logic [BAND_W:0]                               fin_idx;
        logic                                          read_valid;
        logic [9:0]                                    read_code;
        logic                                          far_end_push;
        logic                                          busy;
        logic [NUM_BANDS-1:0][9:0]                     staged;
        logic                                          phase_report;
    } state_s;

    state_s cur;
    state_s next_cur;

    // coarse log2 in tenth dB: 3.0 dB per octave of the leading one
    function automatic logic [15:0] tenth_db(input logic [ACC_W-1:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int k = 0; k < ACC_W; k++) begin
            if (v[k]) begin
                r = 16'(k) * satn_pkg::TENTH_DB_PER_OCTAVE;
            end
        end
        return r;
    endfunction

    logic [15:0]        gain_eff;
    logic [ACC_W-1:0]   rx_term;
    logic [ACC_W-1:0]   tx_term;
    logic [15:0]        tx_db;
    logic [15:0]        rx_db;
    logic signed [17:0] diff;

    always_comb begin
        // R6: diagnostic gain is 0 or 1 (1.0 = 16'h0100 fixed point)
        case (phase)
            satn_pkg::PHASE_DIAG: gain_eff = sc_bit_loadable ? 16'h0100 : 16'h0000; // R6
            default:              gain_eff = sc_gain_sq; // R5 R10 R11
        endcase
        if (phase == satn_pkg::PHASE_SHOWTIME) begin
            rx_term = ACC_W'(sc_rx_power) << 8; // R3
        end else begin
            rx_term = ACC_W'(sc_rx_power) * ACC_W'(gain_eff); // R2 R5
        end
        tx_term = ACC_W'(sc_ref_psd_linear) * ACC_W'(gain_eff); // R7 R8 R9
        tx_db = SPACING_TENTH_DB + tenth_db(cur.tx_acc[cur.fin_idx[BAND_W-1:0]]); // R7
        rx_db = tenth_db(cur.rx_acc[cur.fin_idx[BAND_W-1:0]]); // R2
        diff = 18'(signed'({2'b00, tx_db})) - 18'(signed'({2'b00, rx_db})); // R1

        next_cur = cur;
        next_cur.read_valid = 1'b0;
        next_cur.far_end_push = 1'b0;
        case (cur.state)
            satn_pkg::ST_IDLE: begin
                if (start) begin // R12
                    next_cur.state = satn_pkg::ST_ACCUM;
                    next_cur.dir_us = upstream;
                    next_cur.rx_acc = '0;
                    next_cur.tx_acc = '0;
                    next_cur.busy = 1'b1;
                    next_cur.phase_report = (phase != satn_pkg::PHASE_SHOWTIME);
                end
            end
            satn_pkg::ST_ACCUM: begin
                // R4: only active-set subcarriers with a band index below NUM_BANDS count; direction is not checked
                if (sc_valid && sc_in_active_set && (32'(sc_band) < NUM_BANDS)) begin // R4
                    next_cur.rx_acc[sc_band] = cur.rx_acc[sc_band] + rx_term;
                    next_cur.tx_acc[sc_band] = cur.tx_acc[sc_band] + tx_term;
                end
                if (sc_valid && sc_last) begin
                    next_cur.state = satn_pkg::ST_FINISH;
                    next_cur.fin_idx = '0;
                end
            end
            satn_pkg::ST_FINISH: begin
                // one band per cycle into a staging set, so readers never see a mix
                if (cur.rx_acc[cur.fin_idx[BAND_W-1:0]] == '0 || diff < 0
                    || diff > 18'(satn_pkg::CODE_MAX_VALID)) begin
                    next_cur.staged[cur.fin_idx[BAND_W-1:0]] = satn_pkg::CODE_OUT_OF_RANGE; // R16
                end else begin
                    next_cur.staged[cur.fin_idx[BAND_W-1:0]] = diff[9:0]; // R15
                end
                next_cur.fin_idx = cur.fin_idx + 1'b1;
                if (32'(cur.fin_idx) == NUM_BANDS - 1) begin
                    next_cur.state = satn_pkg::ST_IDLE;
                    next_cur.busy = 1'b0;
                    next_cur.far_end_push = cur.phase_report; // R13
                end
            end
            default: next_cur.state = satn_pkg::ST_IDLE;
        endcase
        if (cur.state == satn_pkg::ST_FINISH && 32'(cur.fin_idx) == NUM_BANDS - 1) begin
            // all bands of the direction commit in the same cycle
            next_cur.codes[cur.dir_us] = next_cur.staged; // R20
        end
        if (read_req) begin // R13 R14
            next_cur.read_valid = 1'b1;
            next_cur.read_code = (32'(read_band) < NUM_BANDS) ? cur.codes[read_upstream][read_band]
                                                               : satn_pkg::CODE_OUT_OF_RANGE;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cur <= '{state: satn_pkg::ST_IDLE, codes: {2*NUM_BANDS{satn_pkg::CODE_OUT_OF_RANGE}}, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign read_valid   = cur.read_valid;
    assign read_code    = cur.read_code;
    assign far_end_push = cur.far_end_push;
    assign busy         = cur.busy;
    // no margin is computed in this block; it only reports margin reference mode 1
    assign margin_reference_mode = satn_pkg::MARGIN_MODE_EXTERNAL; // R17 R18 R19
endmodule

// ---- rtl/satn_pkg.sv ----
// constants for the band signal attenuation calculator
package satn_pkg;
    localparam int CODE_W = 10;
    localparam logic [9:0] CODE_OUT_OF_RANGE = 10'h3FF;
    localparam logic [9:0] CODE_MAX_VALID = 10'h3FE;
    // log domain values are in 0.1 dB units, unsigned
    localparam int LOG_W = 16;
    localparam logic [1:0] PHASE_INIT = 2'h0;
    localparam logic [1:0] PHASE_DIAG = 2'h1;
    localparam logic [1:0] PHASE_SHOWTIME = 2'h2;
    localparam logic [1:0] MARGIN_MODE_EXTERNAL = 2'h1;
    // 10*log10(2) in tenths of dB, used by the log approximation
    localparam logic [15:0] TENTH_DB_PER_OCTAVE = 16'h001E;
    typedef enum logic [1:0] {ST_IDLE, ST_ACCUM, ST_FINISH} state_e;
endpackage

// ---- test/sc_source.sv ----
// far-end subcarrier stream model: one active subcarrier per band per frame
`timescale 1ns/1ps
module sc_source #(
    parameter int NB = 4
) (
    // control from the bench
    input  wire logic        clock,
    input  wire logic        go,
    input  wire logic        loadable,
    input  wire logic [31:0] level,
    input  wire logic [15:0] gain,
    // stream into the block
    output logic             sc_valid,
    output logic             sc_last,
    output logic             sc_in_active_set,
    output logic             sc_bit_loadable,
    output logic [2:0]       sc_band,
    output logic [31:0]      sc_rx_power,
    output logic [31:0]      sc_ref_psd_linear,
    output logic [15:0]      sc_gain_sq
);
    int n = -1;
    always @(posedge clock) begin
        if (go) n <= 0;
        else if (n >= 0) n <= (n == NB - 1) ? -1 : n + 1;
    end
    assign sc_valid = n >= 0;
    assign sc_last = n == NB - 1;
    assign sc_in_active_set = sc_valid;
    assign sc_bit_loadable = sc_valid ? loadable : ~loadable;
    assign sc_band = 3'(n);
    // off frame the data lines are inverted so stale values never match
    assign sc_rx_power = sc_valid ? level : ~level;
    assign sc_ref_psd_linear = sc_valid ? level : ~level;
    assign sc_gain_sq = sc_valid ? gain : ~gain;
endmodule

// ---- test/band_signal_attenuation_calc_chk.sv ----
// port assertions for the band attenuation calculator
`timescale 1ns/1ps
module band_signal_attenuation_calc_chk #(
    parameter int NUM_BANDS = 8,
    parameter int BAND_W    = 3
) (
    input wire logic              clock,
    input wire logic              resetn,
    input wire logic              start,
    input wire logic              sc_valid,
    input wire logic              sc_last,
    input wire logic              read_req,
    input wire logic [BAND_W-1:0] read_band,
    input wire logic              read_valid,
    input wire logic [9:0]        read_code,
    input wire logic              far_end_push,
    input wire logic              busy,
    input wire logic [1:0]        margin_reference_mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    property p_answer; read_req |=> read_valid; endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    property p_quiet; !read_req |=> !read_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("unrequested read answer");
    property p_bad; read_req && read_band >= NUM_BANDS |=> read_code == 10'h3FF; endproperty
    a_bad: assert property (p_bad) else $error("bad band code wrong");
    property p_hold; !read_valid |-> $stable(read_code); endproperty
    a_hold: assert property (p_hold) else $error("code moved without read");
    property p_mode; margin_reference_mode == 2'h1; endproperty
    a_mode: assert property (p_mode) else $error("margin mode wrong");
    property p_start; start && !busy |=> busy; endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_done; busy && sc_valid && sc_last |-> ##[1:16] !busy; endproperty
    a_done: assert property (p_done) else $error("measurement never ends");
    property p_push; far_end_push |-> !busy && $past(busy) ##1 !far_end_push; endproperty
    a_push: assert property (p_push) else $error("push not at completion");
endmodule
bind band_signal_attenuation_calc band_signal_attenuation_calc_chk #(.NUM_BANDS(NUM_BANDS), .BAND_W(BAND_W)) chk (
    .clock(clock), .resetn(resetn), .start(start), .sc_valid(sc_valid), .sc_last(sc_last), .read_req(read_req),
    .read_band(read_band), .read_valid(read_valid), .read_code(read_code), .far_end_push(far_end_push),
    .busy(busy), .margin_reference_mode(margin_reference_mode));

// ---- test/tb_band_signal_attenuation_calc.sv ----
// testbench for the band attenuation calculator
`timescale 1ns/1ps
module tb_band_signal_attenuation_calc;
    logic clock = 0, resetn = 0, start = 0, upstream = 0, read_req = 0, read_upstream = 0, loadable = 0;
    logic [1:0] phase = 2'h0;
    logic [2:0] read_band = 3'h0, sc_band;
    logic [15:0] gain = 16'h0100, sc_gain_sq;
    logic [31:0] level = 32'h0000_1000, sc_rx_power, sc_ref_psd_linear;
    logic sc_valid, sc_last, sc_in_active_set, sc_bit_loadable, read_valid, far_end_push, busy;
    logic [9:0] read_code;
    logic [1:0] margin_reference_mode;
    int fails = 0, comparisons = 0, pushes = 0;
    always #4 clock = ~clock;
    always @(posedge clock) if (far_end_push === 1'b1) pushes++;
    sc_source #(.NB(4)) far_end (.clock(clock), .go(start), .loadable(loadable), .level(level), .gain(gain),
        .sc_valid(sc_valid), .sc_last(sc_last), .sc_in_active_set(sc_in_active_set),
        .sc_bit_loadable(sc_bit_loadable), .sc_band(sc_band), .sc_rx_power(sc_rx_power),
        .sc_ref_psd_linear(sc_ref_psd_linear), .sc_gain_sq(sc_gain_sq));
    band_signal_attenuation_calc #(.NUM_BANDS(4), .BAND_W(3), .PWR_W(32), .SPACING_TENTH_DB(16'h0064)) dut (
        .clock(clock), .resetn(resetn), .start(start), .phase(phase), .upstream(upstream), .sc_valid(sc_valid),
        .sc_last(sc_last), .sc_band(sc_band), .sc_in_active_set(sc_in_active_set), .sc_rx_power(sc_rx_power),
        .sc_ref_psd_linear(sc_ref_psd_linear), .sc_gain_sq(sc_gain_sq), .sc_bit_loadable(sc_bit_loadable),
        .read_req(read_req), .read_upstream(read_upstream), .read_band(read_band), .read_valid(read_valid),
        .read_code(read_code), .far_end_push(far_end_push), .busy(busy),
        .margin_reference_mode(margin_reference_mode));
    task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (fails == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic read(logic up, logic [2:0] band, logic [9:0] exp);
        @(posedge clock);
        read_req <= 1'b1;
        read_upstream <= up;
        read_band <= band;
        @(posedge clock);
        read_req <= 1'b0;
        #1;
        check("read_valid", {9'h000, read_valid}, 10'h001);
        check("read_code", read_code, exp);
    endtask
    task automatic measure(logic [1:0] ph, logic up, logic [15:0] g, logic ld, logic [9:0] push_exp);
        int k = 0;
        int p0 = pushes;
        @(posedge clock);
        start <= 1'b1;
        phase <= ph;
        upstream <= up;
        gain <= g;
        loadable <= ld;
        @(posedge clock);
        start <= 1'b0;
        #1;
        while (busy === 1'b1 && k < 40) begin
            @(posedge clock);
            #1;
            k++;
        end
        @(posedge clock);
        #1;
        check("busy", {9'h000, busy}, 10'h000);
        check("push", 10'(pushes - p0), push_exp);
    endtask
    // diagnostic ignores the message gain, loadable subcarriers count as gain 1
    task automatic t_diag();
        measure(satn_pkg::PHASE_DIAG, 1'b0, 16'h0040, 1'b1, 10'h001);
        for (int b = 0; b < 4; b++) read(1'b0, 3'(b), 10'h064);
    endtask
    task automatic t_diag_dead();
        measure(satn_pkg::PHASE_DIAG, 1'b0, 16'h0100, 1'b0, 10'h001);
        read(1'b0, 3'h2, 10'h3FF);
    endtask
    task automatic t_init_up();
        measure(satn_pkg::PHASE_INIT, 1'b1, 16'h0200, 1'b1, 10'h001);
        for (int b = 0; b < 4; b++) read(1'b1, 3'(b), 10'h064);
        read(1'b0, 3'h0, 10'h3FF);
    endtask
    // showtime leaves rx unweighted, so a doubled gain adds 3.0 dB
    task automatic t_show();
        measure(satn_pkg::PHASE_SHOWTIME, 1'b0, 16'h0200, 1'b1, 10'h000);
        read(1'b0, 3'h1, 10'h082);
    endtask
    task automatic t_bad_band();
        read(1'b0, 3'h5, 10'h3FF);
        read(1'b1, 3'h7, 10'h3FF);
        check("mode", {8'h00, margin_reference_mode}, 10'h001);
    endtask
    initial begin
        #400000;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        read(1'b0, 3'h0, 10'h3FF);
        t_diag();
        t_diag_dead();
        t_init_up();
        t_show();
        t_bad_band();
        report_and_stop();
    end
endmodule
